/* File: iexp_port_regs.sv */
// Notes on behaviour
// - Bit 7 of the port-1 input register reads the live level of the second PHY interrupt pin.
// - Writes to either input register change nothing in the block.
// - Port-0 output bit 0 sets the level driven on the first PHY interrupt pin.
// - Port-0 output bit 1 sets the level driven on the connector MCU reset pin.
// - Port-0 output bit 2 sets the level driven on the connector power-select pin.
// - Port-0 output bits 5 and 6 drive the reference-select pins of clock generators B and A.
// - Port-1 output bits 0 and 1 drive the refclk power-down pins of clock generators A and B.
// - Port-1 output bit 7 sets the level driven on the second PHY interrupt pin.
// - The port-0 direction register at index 16h is read/write, resets to 00, and a 1 makes pin n an output.
// - The port-1 direction register at index 17h is read/write and resets to 00, so upper pins start as inputs.
// - Bit n of the port-1 direction register sets the direction of pin 8 plus n.
//
// The Avalon-MM slave port is this design's own decision.
module iexp_port_regs (
   // Clock and reset.
   input  wire logic                           I_MCLK,
   input  wire logic                           I_RST,
   // Avalon-MM register slave.
   input  wire iexp_pkg::iexp_avs_req_t        I_AVS_REQ,
   output iexp_pkg::iexp_avs_rsp_t             O_AVS_RSP,
   // Expander pins: level seen, value driven, drive enable.
   input  wire logic [iexp_pkg::NUM_PINS-1:0]  I_PIN_LEVEL,
   output iexp_pkg::iexp_pin_drv_t             O_PIN_DRV
);
   import iexp_pkg::*;

   logic [NUM_PINS-1:0] pin_meta_r;
   logic [NUM_PINS-1:0] pin_sync_r;
   iexp_bus_state_t     state_r;
   iexp_bus_state_t     state_nxt;
   logic [DATA_W-1:0]   rdata_r;
   logic [BYTE_W-1:0]   wreg_r [NUM_WREG];

   // Decode of a register index against a word-aligned byte address.
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
      reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
   endfunction

   // Pin levels come from outside the clock domain, so two flops precede any reader.
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         pin_meta_r <= 16'h0000;
         pin_sync_r <= 16'h0000;
      end else begin
         pin_meta_r <= I_PIN_LEVEL;
         pin_sync_r <= pin_meta_r;
      end
   end

   // Request qualification and address decode.
   wire bus_req    = I_AVS_REQ.read | I_AVS_REQ.write;
   wire bus_accept = bus_req & (state_r == BUS_ANSWER);
   wire wr_accept  = bus_accept & I_AVS_REQ.write & I_AVS_REQ.byteenable[0];
   wire hit_p0_in  = reg_hit(I_AVS_REQ.address, IDX_P0_IN);
   wire hit_p1_in  = reg_hit(I_AVS_REQ.address, IDX_P1_IN);
   wire hit_p0_out = reg_hit(I_AVS_REQ.address, IDX_P0_OUT);
   wire hit_p1_out = reg_hit(I_AVS_REQ.address, IDX_P1_OUT);
   wire hit_p0_dir = reg_hit(I_AVS_REQ.address, IDX_P0_DIR);
   wire hit_p1_dir = reg_hit(I_AVS_REQ.address, IDX_P1_DIR);

   // Every access waits exactly one cycle; this gives the read mux a full cycle to settle.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BUS_IDLE:   state_nxt = bus_req ? BUS_ANSWER : BUS_IDLE;
         BUS_ANSWER: state_nxt = BUS_IDLE;
         default:    state_nxt = BUS_IDLE;
      endcase
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         state_r <= BUS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Writable registers in index order; input registers have no storage, so writes to them fall away.
   localparam logic [BYTE_W-1:0] WREG_RST [NUM_WREG] = '{RST_P0_OUT, RST_P1_OUT, RST_P0_DIR, RST_P1_DIR};

   wire [NUM_WREG-1:0] wreg_hit = {hit_p1_dir, hit_p0_dir, hit_p1_out, hit_p0_out};

   // One storage byte per writable register; reserved bits are kept as software wrote them.
   genvar g;
   generate
      for (g = 0; g < NUM_WREG; g++) begin : g_wreg
         always_ff @(posedge I_MCLK or posedge I_RST) begin
            if (I_RST) begin
               wreg_r[g] <= WREG_RST[g];
            end else if (wr_accept && wreg_hit[g]) begin
               wreg_r[g] <= I_AVS_REQ.writedata[BYTE_W-1:0];
            end
         end
      end
   endgenerate

   // Input views show only implemented pins, reserved positions read zero.
   wire [NUM_PINS-1:0] pin_seen = pin_sync_r & PIN_IMPL_MASK;

   // Read selection; unmapped addresses answer with zero.
   wire [BYTE_W-1:0] rd_byte =
      hit_p0_in  ? pin_seen[BYTE_W-1:0]      :
      hit_p1_in  ? pin_seen[NUM_PINS-1:BYTE_W] :
      hit_p0_out ? wreg_r[0]                 :
      hit_p1_out ? wreg_r[1]                 :
      hit_p0_dir ? wreg_r[2]                 :
      hit_p1_dir ? wreg_r[3]                 : 8'h00;
   wire rd_mapped = hit_p0_in | hit_p1_in | hit_p0_out | hit_p1_out | hit_p0_dir | hit_p1_dir;
   wire [DATA_W-1:0] rd_word = rd_mapped ? {24'h00_0000, rd_byte} : RD_UNMAPPED;

   // Read data is caught on the first request cycle and stands through the answer cycle.
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         rdata_r <= 32'h0000_0000;
      end else if (I_AVS_REQ.read && state_r == BUS_IDLE) begin
         rdata_r <= rd_word;
      end
   end

   assign O_AVS_RSP.readdata    = rdata_r;
   assign O_AVS_RSP.waitrequest = bus_req & (state_r == BUS_IDLE);

   // Pin drive: values and enables straight from register flops, reserved pins never drive.
   wire [NUM_PINS-1:0] out_word = {wreg_r[1], wreg_r[0]};
   wire [NUM_PINS-1:0] dir_word = {wreg_r[3], wreg_r[2]};
   assign O_PIN_DRV.out = out_word & PIN_IMPL_MASK;
   assign O_PIN_DRV.oe  = dir_word & PIN_IMPL_MASK;

   // Helper views for the checks below.
   wire [NUM_PINS-1:0] drv_out = O_PIN_DRV.out;
   wire [NUM_PINS-1:0] drv_oe  = O_PIN_DRV.oe;
   wire [BYTE_W-1:0]   wbyte   = I_AVS_REQ.writedata[BYTE_W-1:0];
   wire                rd_ans  = bus_accept & I_AVS_REQ.read;

   chk_bus_answer_bound: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      bus_req |-> ##[0:1] !O_AVS_RSP.waitrequest)
      else $error("Bus request not answered within one cycle.");

   chk_p1_input_live: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p1_in |-> rdata_r[7] == $past(pin_sync_r[PIN_PHY_IRQ_B]))
      else $error("Port-1 input bit 7 does not follow the PHY B pin.");

   chk_input_write_null: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && (hit_p0_in || hit_p1_in) |=> $stable(drv_out) && $stable(drv_oe))
      else $error("Write to an input register changed pin drive.");

   chk_phy_a_level: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p0_out |=> drv_out[PIN_PHY_IRQ_A] == $past(wbyte[0]))
      else $error("PHY A pin level does not match written bit 0.");

   chk_conn_rst_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_out[PIN_CONN_RST_N]) |-> $past(wr_accept && hit_p0_out))
      else $error("Connector reset level changed without a port-0 output write.");

   chk_conn_pwrsel_level: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p0_out ##1 !(wr_accept && hit_p0_out)[*2]
      |-> drv_out[PIN_CONN_PWRSEL] == $past(wbyte[2], 2))
      else $error("Power-select level did not hold the written value.");

   chk_clk_refsel_pair: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p0_out |=>
      {drv_out[PIN_CLKA_REFSEL], drv_out[PIN_CLKB_REFSEL]} == $past(wbyte[6:5]))
      else $error("Reference-select pins do not match bits 6 and 5.");

   chk_clk_pd_pair: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p1_out |=>
      {drv_out[PIN_CLKB_PD], drv_out[PIN_CLKA_PD]} == $past(wbyte[1:0]))
      else $error("Power-down pins do not match port-1 bits 1 and 0.");

   chk_phy_b_level: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $rose(drv_out[PIN_PHY_IRQ_B]) |-> $past(wr_accept && hit_p1_out && wbyte[7]))
      else $error("PHY B pin rose without a write of port-1 bit 7.");

   chk_p0_dir_write: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p0_dir |=> drv_oe[BYTE_W-1:0] == ($past(wbyte) & PIN_IMPL_MASK[BYTE_W-1:0]))
      else $error("Port-0 enables do not follow the direction write.");

   chk_p1_dir_readback: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p1_dir |-> rdata_r[BYTE_W-1:0] == wreg_r[3])
      else $error("Port-1 direction read back differs from write.");

   chk_p1_dir_map: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p1_dir |=> drv_oe[NUM_PINS-1:BYTE_W] == ($past(wbyte) & PIN_IMPL_MASK[NUM_PINS-1:BYTE_W]))
      else $error("Port-1 enables are not mapped to pins 8 and up.");

   chk_out_no_enable: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && (hit_p0_out || hit_p1_out) |=> $stable(drv_oe))
      else $error("Output value write altered a drive enable.");

   // With no request up the slave must never stall the bus.
   chk_idle_no_wait: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      !bus_req |-> !O_AVS_RSP.waitrequest)
      else $error("Waitrequest high without a request.");

   // A held request sees exactly one wait cycle.
   chk_wait_one_cycle: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      bus_req && O_AVS_RSP.waitrequest |=> !O_AVS_RSP.waitrequest)
      else $error("Second wait cycle inserted.");

   // The answer cycle always hands the slave back to idle.
   chk_answer_to_idle: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      bus_accept |=> state_r == BUS_IDLE)
      else $error("Slave did not return to idle after an answer.");

   // Port-0 input view follows the synchronised low pins, reserved ones masked.
   chk_p0_input_live: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p0_in |-> rdata_r[BYTE_W-1:0] == ($past(pin_sync_r[BYTE_W-1:0]) & PIN_IMPL_MASK[BYTE_W-1:0]))
      else $error("Port-0 input view does not follow the pins.");

   // Reserved port-1 input positions read as zero.
   chk_p1_in_reserved: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p1_in |-> rdata_r[6:2] == 5'h00)
      else $error("Reserved port-1 input bits read nonzero.");

   // Only the low byte of a word carries register data.
   chk_rd_upper_zero: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans |-> rdata_r[DATA_W-1:BYTE_W] == 24'h00_0000)
      else $error("Upper read data bits are nonzero.");

   // Unmapped and misaligned reads answer with the fixed pattern.
   chk_unmapped_zero: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && !rd_mapped |-> rdata_r == RD_UNMAPPED)
      else $error("Unmapped read returned data.");

   // A write with lane 0 disabled is answered but changes nothing.
   chk_masked_write_null: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      bus_accept && I_AVS_REQ.write && !I_AVS_REQ.byteenable[0] |=> $stable(drv_out) && $stable(drv_oe))
      else $error("Masked write changed pin drive.");

   // Port-0 output reads back what was stored.
   chk_p0_out_readback: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p0_out |-> rdata_r[BYTE_W-1:0] == wreg_r[0])
      else $error("Port-0 output read back differs.");

   // Port-1 output reads back what was stored.
   chk_p1_out_readback: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p1_out |-> rdata_r[BYTE_W-1:0] == wreg_r[1])
      else $error("Port-1 output read back differs.");

   // Port-0 direction reads back what was stored.
   chk_p0_dir_readback: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      rd_ans && hit_p0_dir |-> rdata_r[BYTE_W-1:0] == wreg_r[2])
      else $error("Port-0 direction read back differs.");

   // Reserved positions never drive, whatever software stored there.
   chk_reserved_no_drive: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      (drv_oe & ~PIN_IMPL_MASK) == 16'h0000 && (drv_out & ~PIN_IMPL_MASK) == 16'h0000)
      else $error("Reserved pin position is driven.");

   // The PHY B pin falls only on a write of port-1 bit 7 as zero.
   chk_phy_b_fall: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $fell(drv_out[PIN_PHY_IRQ_B]) |-> $past(wr_accept && hit_p1_out && !wbyte[7]))
      else $error("PHY B pin fell without a write of zero.");

   // The PHY B pin takes the written bit 7.
   chk_phy_b_write: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p1_out |=> drv_out[PIN_PHY_IRQ_B] == $past(wbyte[7]))
      else $error("PHY B pin does not match written bit 7.");

   // The PHY A pin moves only on a port-0 output write.
   chk_phy_a_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_out[PIN_PHY_IRQ_A]) |-> $past(wr_accept && hit_p0_out))
      else $error("PHY A pin changed without a port-0 output write.");

   // The connector reset pin takes the written bit 1.
   chk_conn_rst_level: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      wr_accept && hit_p0_out |=> drv_out[PIN_CONN_RST_N] == $past(wbyte[1]))
      else $error("Connector reset pin does not match written bit 1.");

   // The power-select pin moves only on a port-0 output write.
   chk_pwrsel_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_out[PIN_CONN_PWRSEL]) |-> $past(wr_accept && hit_p0_out))
      else $error("Power-select pin changed without a write.");

   // The power-down pins move only on a port-1 output write.
   chk_pd_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_out[PIN_CLKB_PD:PIN_CLKA_PD]) |-> $past(wr_accept && hit_p1_out))
      else $error("Power-down pins changed without a write.");

   // Low-byte enables move only on a port-0 direction write.
   chk_dir_p0_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_oe[BYTE_W-1:0]) |-> $past(wr_accept && hit_p0_dir))
      else $error("Port-0 enables changed without a direction write.");

   // High-byte enables move only on a port-1 direction write.
   chk_dir_p1_cause: assert property (
      @(posedge I_MCLK) disable iff (I_RST)
      $changed(drv_oe[NUM_PINS-1:BYTE_W]) |-> $past(wr_accept && hit_p1_dir))
      else $error("Port-1 enables changed without a direction write.");

endmodule

/* File: iexp_pkg.sv */
package iexp_pkg;

   // Bus geometry.
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int BE_W     = 4;
   localparam int BYTE_W   = 8;
   localparam int NUM_PINS = 16;
   localparam int IDX_W    = 6;
   localparam int NUM_WREG = 4;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_P0_IN  = 6'h12;
   localparam logic [IDX_W-1:0] IDX_P1_IN  = 6'h13;
   localparam logic [IDX_W-1:0] IDX_P0_OUT = 6'h14;
   localparam logic [IDX_W-1:0] IDX_P1_OUT = 6'h15;
   localparam logic [IDX_W-1:0] IDX_P0_DIR = 6'h16;
   localparam logic [IDX_W-1:0] IDX_P1_DIR = 6'h17;

   // Reset values of the writable registers, in index order from IDX_P0_OUT.
   localparam logic [BYTE_W-1:0] RST_P0_OUT = 8'h00;
   localparam logic [BYTE_W-1:0] RST_P1_OUT = 8'h00;
   localparam logic [BYTE_W-1:0] RST_P0_DIR = 8'h00;
   localparam logic [BYTE_W-1:0] RST_P1_DIR = 8'h00;
   localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;

   // Pin positions on the 16-pin expander.
   localparam int PIN_PHY_IRQ_A   = 0;
   localparam int PIN_CONN_RST_N  = 1;
   localparam int PIN_CONN_PWRSEL = 2;
   localparam int PIN_CLKB_REFSEL = 5;
   localparam int PIN_CLKA_REFSEL = 6;
   localparam int PIN_CLKA_PD     = 8;
   localparam int PIN_CLKB_PD     = 9;
   localparam int PIN_PHY_IRQ_B   = 15;

   // Pins that exist; reserved positions never drive and read as zero in the input views.
   localparam logic [NUM_PINS-1:0] PIN_IMPL_MASK = 16'h8367;

   // Avalon-MM slave request and answer.
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0]   byteenable;
   } iexp_avs_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic              waitrequest;
   } iexp_avs_rsp_t;

   // Drive side of the expander pins.
   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
   } iexp_pin_drv_t;

   typedef enum logic {BUS_IDLE, BUS_ANSWER} iexp_bus_state_t;

endpackage

/* File: iexp_pin_model.sv */
module iexp_pin_model (
   // Drive side of the block under test.
   input  wire iexp_pkg::iexp_pin_drv_t       i_drv,
   // Levels the board puts on pins that the block leaves undriven.
   input  wire logic [iexp_pkg::NUM_PINS-1:0] i_far,
   // Resolved wire levels.
   output logic [iexp_pkg::NUM_PINS-1:0]      o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   import iexp_pkg::*;

   // There is no pull on these lines, so a released pin shows whatever the board source drives.
   assign o_level = (i_drv.out & i_drv.oe) | (i_far & ~i_drv.oe);
endmodule

/* File: tb_io_expander_port_regs.sv */
module tb_io_expander_port_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import iexp_pkg::*;

   localparam logic [7:0] ADDRS [8] = '{8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h51, 8'h60};

   logic          mclk;
   logic          rst;
   iexp_avs_req_t req;
   iexp_avs_rsp_t rsp;
   iexp_pin_drv_t drv;
   logic [15:0]   pin_level;
   logic [15:0]   far_level;
   logic [31:0]   seed;
   logic [31:0]   rd;
   logic [7:0]    mdl [4];
   int            mismatches;
   int            n_compared;

   iexp_port_regs dut (.I_MCLK(mclk), .I_RST(rst), .I_AVS_REQ(req), .O_AVS_RSP(rsp),
                       .I_PIN_LEVEL(pin_level), .O_PIN_DRV(drv));
   iexp_pin_model board (.i_drv(drv), .i_far(far_level), .o_level(pin_level));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Expected read data from the byte model and the board levels.
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      logic [15:0] dir;
      logic [15:0] lv;
      dir = {mdl[3], mdl[2]} & PIN_IMPL_MASK;
      lv = (({mdl[1], mdl[0]} & dir) | (far_level & ~dir)) & PIN_IMPL_MASK;
      case (a)
         8'h48: return {24'h0, lv[7:0]};
         8'h4C: return {24'h0, lv[15:8]};
         8'h50, 8'h54, 8'h58, 8'h5C: return {24'h0, mdl[(a - 8'h50) >> 2]};
         default: return 32'h0;
      endcase
   endfunction

   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t read got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t pins got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; the request holds until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      @(posedge mclk);
      req <= '{read: !wr, write: wr, address: a, writedata: {seed[31:8], d}, byteenable: be};
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (rsp.waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         mismatches++;
         test_done();
      end
      q = rsp.readdata;
      req <= '0;
   endtask

   // Pins must follow the model after every write.
   task automatic check_pins();
      cmp_pin(drv.oe, {mdl[3], mdl[2]} & PIN_IMPL_MASK);
      cmp_pin(drv.out, {mdl[1], mdl[0]} & PIN_IMPL_MASK);
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial begin
      logic [7:0] a;
      logic [7:0] d;
      logic [3:0] be;
      rst = 1'b1;
      req = '0;
      far_level = 16'hA5C3;
      seed = 32'hf9a3;
      mismatches = 0;
      n_compared = 0;
      mdl = '{default: 8'h00};
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      // Reset values, unmapped reads and released pins.
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, ADDRS[i] & 8'hFC, 8'h00, 4'hF, rd);
         cmp_rd(rd, exp_rd(ADDRS[i] & 8'hFC));
      end
      check_pins();
      // Random traffic, including writes to input, unmapped and misaligned places and masked lanes.
      for (int i = 0; i < 200; i++) begin
         seed = xorshift(seed);
         far_level <= seed[31:16];
         a = ADDRS[seed[2:0]];
         d = seed[15:8] & (a[2] ? 8'h83 : 8'h67);
         be = (seed[5:4] == 2'b00) ? 4'h0 : 4'hF;
         bus(1'b1, a, d, be, rd);
         if (be[0] && a >= 8'h50 && a <= 8'h5C && a[1:0] == 2'b00) begin
            mdl[(a - 8'h50) >> 2] = d;
         end
         repeat (2) @(posedge mclk);
         check_pins();
         a = ADDRS[seed[6:4] ^ seed[2:0]] & 8'hFC;
         bus(1'b0, a, 8'h00, 4'hF, rd);
         cmp_rd(rd, exp_rd(a));
      end
      // A second reset in mid-run clears every register.
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      mdl = '{default: 8'h00};
      bus(1'b0, 8'h5C, 8'h00, 4'hF, rd);
      cmp_rd(rd, 32'h0);
      check_pins();
      test_done();
   end
endmodule
